// *** hw/srdi_cmd_core.sv ***
// release(10), depopulate-and-truncate and identifier report interpreter
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "srdi_consts.svh"

module srdi_cmd_core #(
    parameter int NUM_ELEM = 4,
    parameter int ID_BYTES = 16,
    parameter logic [63:0] ELEM_BLOCKS = 64'h0000_0000_0400_0000
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        nv_ready_i,
    input  wire logic        media_done_i,
    input  wire logic        media_fail_i,
    output logic             depop_req_o,
    output logic      [31:0] depop_elem_o,
    output logic      [63:0] depop_cap_o,
    output logic             fmt_corrupt_o
);
    import srdi_pkg::*;

    if (NUM_ELEM < 1 || NUM_ELEM > `SRDI_ELEM_MAX) begin : g_elem_chk
        $error("NUM_ELEM out of range");
    end
    if (ID_BYTES < 1 || ID_BYTES > `SRDI_ID_MAX) begin : g_id_chk
        $error("ID_BYTES out of range");
    end

    srdi_state_s r_reg;
    srdi_state_s r_next;

    // nonvolatile identifier store: no reset, so it outlives any reset
    logic [7:0]  id_mem [`SRDI_ID_MAX];
    logic [7:0]  id_len_reg = 8'h00;
    logic        set_id;

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        logic [31:0] m;
        m = o;
        for (int i = 0; i < 4; i++)
            if (s[i])
                m[i*8 +: 8] = d[i*8 +: 8];
        return m;
    endfunction

    // bus words are big-endian: bits 31:24 carry the lowest byte number
    function automatic logic [31:0] bswap(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    function automatic srdi_result_s mk(input logic [3:0] k,
                                        input logic [7:0] a,
                                        input logic [7:0] q);
        srdi_result_s x;
        x.stat = (k == `SRDI_SK_NONE) ? `SRDI_ST_GOOD : `SRDI_ST_CHECK;
        x.skey = k;
        x.asc  = a;
        x.ascq = q;
        return x;
    endfunction

    function automatic logic is_medium(input logic [7:0] op);
        case (op)
            8'h08, 8'h0a, 8'h28, 8'h2a, 8'h88, 8'h8a: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    logic              req;
    logic [5:0]        widx;
    logic [7:0]        op;
    logic [4:0]        sa;
    logic              is_rel;
    logic              is_dep;
    logic              is_rep;
    logic [63:0]       req_cap;
    logic [63:0]       tgt_cap;
    logic [31:0]       eid;
    logic              elem_ok;
    logic              cap_ok;
    logic [31:0]       alloc;
    logic [31:0]       full_len;
    logic [31:0]       xbyte_idx;
    logic [7:0]        xbyte;
    logic              lun_bad;

    assign req     = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    assign widx    = wb_adr_i[7:2];
    assign op      = r_reg.cdb[0];
    assign sa      = r_reg.cdb[1][4:0];
    assign is_rel  = (op == `SRDI_OP_REL10);
    assign is_dep  = (op == `SRDI_OP_SA16) && (sa == `SRDI_SA_DEPOP);
    assign is_rep  = (op == `SRDI_OP_SA12) && (sa == `SRDI_SA_REPID);
    assign req_cap = {r_reg.cdb[2], r_reg.cdb[3], r_reg.cdb[4],
                      r_reg.cdb[5], r_reg.cdb[6], r_reg.cdb[7],
                      r_reg.cdb[8], r_reg.cdb[9]};
    assign eid     = {r_reg.cdb[10], r_reg.cdb[11],
                      r_reg.cdb[12], r_reg.cdb[13]};
    assign alloc   = {r_reg.cdb[6], r_reg.cdb[7],
                      r_reg.cdb[8], r_reg.cdb[9]};
    assign lun_bad = ({r_reg.cdb[4], r_reg.cdb[5]} != 16'h0000);
    // zero asks the target to drop exactly one element's worth of blocks
    assign tgt_cap = (req_cap == 64'h0) ? r_reg.cap - ELEM_BLOCKS
                                        : req_cap;
    assign cap_ok  = (r_reg.cap > ELEM_BLOCKS) &&
                     (tgt_cap != 64'h0) &&
                     (tgt_cap <= r_reg.cap - ELEM_BLOCKS);
    // ids 1..NUM_ELEM are the storage elements; others are not type 01h
    assign elem_ok = (eid != 32'h0) && (eid <= 32'(NUM_ELEM)) &&
                     r_reg.elem_en[3'(eid - 32'h1)];
    assign full_len  = `SRDI_LEN_HDR + {24'h0, id_len_reg};
    assign xbyte_idx = r_reg.xidx - `SRDI_LEN_HDR;

    always_comb begin
        if (r_reg.xidx < `SRDI_LEN_HDR)
            // identifier length id_len_reg, header not counted, even when truncated by allocation
            xbyte = 8'({24'h0, id_len_reg} >> (8'd24 -
                    8'(r_reg.xidx[1:0]) * 8'd8));
        else
            xbyte = id_mem[xbyte_idx[3:0]];
    end

    assign set_id = req && wb_we_i && (widx == `SRDI_A_CTRL) &&
                    wb_sel_i[0] && wb_dat_i[`SRDI_C_SETID] &&
                    r_reg.nv_ok && (r_reg.stg_len <= 8'(ID_BYTES));

    always_ff @(posedge clk_i) begin
        if (set_id) begin
            id_len_reg <= r_reg.stg_len;
            for (int i = 0; i < `SRDI_ID_MAX; i++)
                id_mem[i] <= r_reg.stg[i];
        end
    end

    always_comb begin
        r_next = r_reg;
        r_next.ack = req;
        r_next.nv_sync = {r_reg.nv_sync[1:0], nv_ready_i};
        if (r_reg.nv_sync[1] == r_reg.nv_sync[2])
            r_next.nv_ok = r_reg.nv_sync[2];
        if (req && !wb_we_i) begin
            case (widx)
                `SRDI_A_CTRL:   r_next.rdata = {27'h0, r_reg.fmt_bad,
                                                r_reg.ucode, 3'h0};
                `SRDI_A_STAT:   r_next.rdata = {28'h0,
                                    r_reg.st == SRDI_DATA, r_reg.nv_ok,
                                    r_reg.done, r_reg.st != SRDI_IDLE};
                `SRDI_A_SENSE:  r_next.rdata = {r_reg.res.ascq,
                                    r_reg.res.asc, 4'h0, r_reg.res.skey,
                                    r_reg.res.stat};
                `SRDI_A_INIT:   r_next.rdata = {24'h0, r_reg.initiator};
                `SRDI_A_CAPHI:  r_next.rdata = r_reg.cap[63:32];
                `SRDI_A_CAPLO:  r_next.rdata = r_reg.cap[31:0];
                `SRDI_A_DATA:   r_next.rdata = (r_reg.st == SRDI_DATA) ?
                                               {24'h0, xbyte} : 32'h0;
                `SRDI_A_XLEN:   r_next.rdata = r_reg.xlen;
                `SRDI_A_ELEMEN: r_next.rdata = {24'h0, r_reg.elem_en};
                `SRDI_A_STLEN:  r_next.rdata = {24'h0, r_reg.stg_len};
                `SRDI_A_RESV:   r_next.rdata = {23'h0, r_reg.res_held,
                                                r_reg.res_owner};
                default: begin
                    if (widx <= `SRDI_A_CDB3)
                        r_next.rdata = bswap(r_reg.cdb[widx[1:0]*4 +: 4]);
                    else if (widx >= `SRDI_A_STG0 && widx <= `SRDI_A_STG3)
                        r_next.rdata = bswap(r_reg.stg[widx[1:0]*4 +: 4]);
                    else
                        r_next.rdata = 32'h0;
                end
            endcase
        end
        if (req && wb_we_i) begin
            case (widx)
                `SRDI_A_CTRL: begin
                    if (wb_sel_i[0]) begin
                        r_next.ucode = wb_dat_i[`SRDI_C_UCODE];
                        if (wb_dat_i[`SRDI_C_FMTOK])
                            r_next.fmt_bad = 1'b0;
                        if (wb_dat_i[`SRDI_C_START] &&
                            r_reg.st == SRDI_IDLE) begin
                            r_next.st   = SRDI_EXEC;
                            r_next.done = 1'b0;
                        end
                    end
                end
                `SRDI_A_INIT: r_next.initiator =
                    8'(merge({24'h0, r_reg.initiator}, wb_dat_i, wb_sel_i));
                `SRDI_A_CAPHI: r_next.cap[63:32] =
                    merge(r_reg.cap[63:32], wb_dat_i, wb_sel_i);
                `SRDI_A_CAPLO: r_next.cap[31:0] =
                    merge(r_reg.cap[31:0], wb_dat_i, wb_sel_i);
                `SRDI_A_ELEMEN: r_next.elem_en =
                    8'(merge({24'h0, r_reg.elem_en}, wb_dat_i, wb_sel_i));
                `SRDI_A_STLEN: r_next.stg_len =
                    8'(merge({24'h0, r_reg.stg_len}, wb_dat_i, wb_sel_i));
                // software loads the reservation; commands only release it
                `SRDI_A_RESV: {r_next.res_held, r_next.res_owner} =
                    9'(merge({23'h0, r_reg.res_held, r_reg.res_owner},
                             wb_dat_i, wb_sel_i));
                default: begin
                    // the command bytes are frozen while a command runs
                    if (widx <= `SRDI_A_CDB3 && r_reg.st == SRDI_IDLE)
                        r_next.cdb[widx[1:0]*4 +: 4] = bswap(merge(
                            bswap(r_reg.cdb[widx[1:0]*4 +: 4]),
                            wb_dat_i, wb_sel_i));
                    else if (widx >= `SRDI_A_STG0 && widx <= `SRDI_A_STG3)
                        r_next.stg[widx[1:0]*4 +: 4] = bswap(merge(
                            bswap(r_reg.stg[widx[1:0]*4 +: 4]),
                            wb_dat_i, wb_sel_i));
                end
            endcase
        end
        case (r_reg.st)
            SRDI_IDLE: ;
            // every check decides here; media and data start only after
            SRDI_EXEC: begin
                r_next.st   = SRDI_IDLE;
                r_next.done = 1'b1;
                r_next.res  = mk(`SRDI_SK_NONE, `SRDI_ASC_NONE, 8'h00);
                if (is_rel) begin
                    // reservation id and extent bytes are never looked at
                    if (r_reg.cdb[1][`SRDI_TP_BIT])
                        r_next.res = mk(`SRDI_SK_ILL, `SRDI_ASC_FIELD, 8'h00);
                    else if (r_reg.res_held &&
                             r_reg.res_owner == r_reg.initiator)
                        r_next.res_held = 1'b0;
                end else if (is_dep) begin
                    if (r_reg.ucode)
                        r_next.res = mk(`SRDI_SK_NRDY, `SRDI_ASC_NRDY,
                                        `SRDI_Q_UCODE);
                    else if (!elem_ok || !cap_ok)
                        r_next.res = mk(`SRDI_SK_ILL, `SRDI_ASC_FIELD, 8'h00);
                    else begin
                        r_next.st        = SRDI_MEDIA;
                        r_next.done      = 1'b0;
                        r_next.depop_req = 1'b1;
                        r_next.dep_elem  = eid;
                        r_next.new_cap   = tgt_cap;
                    end
                end else if (is_rep) begin
                    if (lun_bad)
                        r_next.res = mk(`SRDI_SK_ILL, `SRDI_ASC_FIELD, 8'h00);
                    else if (!r_reg.nv_ok)
                        r_next.res = mk(`SRDI_SK_NRDY, `SRDI_ASC_NRDY, 8'h00);
                    else begin
                        r_next.xlen = (alloc < full_len) ? alloc
                                                         : full_len;
                        r_next.xidx = 32'h0;
                        if (r_next.xlen != 32'h0) begin
                            r_next.st   = SRDI_DATA;
                            r_next.done = 1'b0;
                        end
                    end
                end else if (is_medium(op) && r_reg.fmt_bad)
                    r_next.res = mk(`SRDI_SK_MED, `SRDI_ASC_DEPOP,
                                    `SRDI_Q_DEPOP);
                else if (!is_medium(op))
                    r_next.res = mk(`SRDI_SK_ILL, `SRDI_ASC_BADOP, 8'h00);
            end
            SRDI_MEDIA: begin
                if (media_done_i) begin
                    r_next.depop_req = 1'b0;
                    r_next.st        = SRDI_IDLE;
                    r_next.done      = 1'b1;
                    if (media_fail_i) begin
                        // set wins over a format-good clear in this cycle
                        r_next.fmt_bad = 1'b1;
                        r_next.res = mk(`SRDI_SK_MED, `SRDI_ASC_DEPOP,
                                        `SRDI_Q_DEPOP);
                    end else
                        r_next.cap = r_reg.new_cap;
                end
            end
            SRDI_DATA: begin
                // each read of the data register hands out one byte
                if (req && !wb_we_i && widx == `SRDI_A_DATA) begin
                    r_next.xidx = r_reg.xidx + 32'h1;
                    if (r_next.xidx == r_reg.xlen) begin
                        r_next.st   = SRDI_IDLE;
                        r_next.done = 1'b1;
                    end
                end
            end
            default: r_next.st = SRDI_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            r_reg         <= '0;
            r_reg.st      <= SRDI_IDLE;
            r_reg.cap     <= `SRDI_CAP_RST;
            r_reg.elem_en <= 8'hff;
        end else begin
            r_reg <= r_next;
        end
    end

    assign wb_dat_o      = r_reg.rdata;
    assign wb_ack_o      = r_reg.ack;
    assign depop_req_o   = r_reg.depop_req;
    assign depop_elem_o  = r_reg.dep_elem;
    assign depop_cap_o   = r_reg.new_cap;
    assign fmt_corrupt_o = r_reg.fmt_bad;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic ex;
    assign ex = (r_reg.st == SRDI_EXEC);

    a_ack_one_cycle: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");
    a_thirdparty_chk: assert property (
        ex && is_rel && r_reg.cdb[1][`SRDI_TP_BIT] |=>
        r_reg.done && r_reg.res.skey == `SRDI_SK_ILL &&
        r_reg.res.asc == `SRDI_ASC_FIELD)
        else $error("third party release not refused");
    a_release_kept: assert property (
        ex && is_rel && !r_reg.cdb[1][`SRDI_TP_BIT] && r_reg.res_held &&
        r_reg.res_owner != r_reg.initiator |=>
        r_reg.res_held && r_reg.res.stat == `SRDI_ST_GOOD)
        else $error("foreign reservation altered");
    a_cap_kept: assert property (
        ex && is_dep && !r_reg.ucode && !cap_ok |=>
        $stable(r_reg.cap) && !depop_req_o &&
        r_reg.res.asc == `SRDI_ASC_FIELD)
        else $error("bad capacity not refused");
    a_ucode_block: assert property (
        ex && is_dep && r_reg.ucode |=> r_reg.res.skey == `SRDI_SK_NRDY &&
        r_reg.res.ascq == `SRDI_Q_UCODE && !depop_req_o)
        else $error("depopulate ran with microcode pending");
    a_depop_fail: assert property (
        r_reg.st == SRDI_MEDIA && media_done_i && media_fail_i |=>
        fmt_corrupt_o && r_reg.res.skey == `SRDI_SK_MED)
        else $error("failed depopulate did not corrupt format");
    a_fmt_block: assert property (
        ex && is_medium(op) && r_reg.fmt_bad |=>
        r_reg.res.asc == `SRDI_ASC_DEPOP && r_reg.res.skey == `SRDI_SK_MED)
        else $error("medium access passed while format corrupt");
    a_lun_chk: assert property (
        ex && is_rep && lun_bad |=> r_reg.st == SRDI_IDLE &&
        r_reg.res.skey == `SRDI_SK_ILL)
        else $error("nonzero unit number accepted");
    a_nv_notready: assert property (
        ex && is_rep && !lun_bad && !r_reg.nv_ok |=> r_reg.done &&
        r_reg.res.skey == `SRDI_SK_NRDY)
        else $error("report waited on unready store");
    a_xfer_trunc: assert property (
        ex && is_rep && !lun_bad && r_reg.nv_ok && alloc < full_len |=>
        r_reg.xlen == $past(alloc))
        else $error("transfer not cut to allocation");

    c_release: cover property (ex && is_rel ##1 r_reg.done);
    c_depop_ok: cover property (r_reg.st == SRDI_MEDIA && media_done_i &&
                                !media_fail_i);
    c_report: cover property (r_reg.st == SRDI_DATA ##[1:40]
                              r_reg.st == SRDI_IDLE);
endmodule // srdi_cmd_core

// *** hw/srdi_consts.svh ***
// offsets, field positions, codes and reset values of the command block
`ifndef SRDI_CONSTS_SVH
`define SRDI_CONSTS_SVH
`define SRDI_A_CDB0    6'h00
`define SRDI_A_CDB3    6'h03
`define SRDI_A_CTRL    6'h04
`define SRDI_A_STAT    6'h05
`define SRDI_A_SENSE   6'h06
`define SRDI_A_INIT    6'h07
`define SRDI_A_CAPHI   6'h08
`define SRDI_A_CAPLO   6'h09
`define SRDI_A_DATA    6'h0a
`define SRDI_A_XLEN    6'h0b
`define SRDI_A_ELEMEN  6'h0c
`define SRDI_A_STLEN   6'h0d
`define SRDI_A_RESV    6'h0e
`define SRDI_A_STG0    6'h10
`define SRDI_A_STG3    6'h13
`define SRDI_C_START   0
`define SRDI_C_SETID   1
`define SRDI_C_FMTOK   2
`define SRDI_C_UCODE   3
`define SRDI_C_FMTBAD  4
`define SRDI_OP_REL10  8'h57
`define SRDI_OP_SA16   8'h9e
`define SRDI_SA_DEPOP  5'h18
`define SRDI_OP_SA12   8'ha3
`define SRDI_SA_REPID  5'h05
`define SRDI_TP_BIT    4
`define SRDI_ST_GOOD   8'h00
`define SRDI_ST_CHECK  8'h02
`define SRDI_SK_NONE   4'h0
`define SRDI_SK_NRDY   4'h2
`define SRDI_SK_MED    4'h3
`define SRDI_SK_ILL    4'h5
`define SRDI_ASC_NONE  8'h00
`define SRDI_ASC_NRDY  8'h04
`define SRDI_ASC_BADOP 8'h20
`define SRDI_ASC_FIELD 8'h24
`define SRDI_ASC_DEPOP 8'h31
`define SRDI_Q_UCODE   8'h1a
`define SRDI_Q_DEPOP   8'h03
`define SRDI_ELEM_MAX  8
`define SRDI_ID_MAX    16
`define SRDI_LEN_HDR   32'h0000_0004
`define SRDI_CAP_RST   64'h0000_0000_1000_0000
`endif

// *** hw/srdi_pkg.sv ***
// types shared by the command block
package srdi_pkg;
    typedef enum logic [3:0] {
        SRDI_IDLE  = 4'b0001,
        SRDI_EXEC  = 4'b0010,
        SRDI_MEDIA = 4'b0100,
        SRDI_DATA  = 4'b1000
    } srdi_state_e;

    typedef struct packed {
        logic [7:0] stat;
        logic [3:0] skey;
        logic [7:0] asc;
        logic [7:0] ascq;
    } srdi_result_s;

    typedef struct packed {
        srdi_state_e        st;
        logic [15:0][7:0]   cdb;
        logic [7:0]         initiator;
        logic               res_held;
        logic [7:0]         res_owner;
        logic [63:0]        cap;
        logic [63:0]        new_cap;
        logic [31:0]        dep_elem;
        logic               depop_req;
        logic [7:0]         elem_en;
        logic               ucode;
        logic               fmt_bad;
        logic               done;
        srdi_result_s       res;
        logic [31:0]        xlen;
        logic [31:0]        xidx;
        logic [7:0]         stg_len;
        logic [15:0][7:0]   stg;
        logic [2:0]         nv_sync;
        logic               nv_ok;
        logic               ack;
        logic [31:0]        rdata;
    } srdi_state_s;
endpackage

// *** verification/srdi_media_model.sv ***
// media side responder that finishes depopulation requests
`timescale 1ns/1ps
module srdi_media_model (
    input  wire logic clk_i,
    input  wire logic req_i,
    input  wire logic fail_mode_i,
    output logic      done_o,
    output logic      fail_o
);
    int unsigned cnt = 0;
    int unsigned lim = 2;
    initial done_o = 1'b0;
    initial fail_o = 1'b0;
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        // not qualifying: show the opposite of a real outcome
        fail_o <= ~fail_mode_i;
        if (req_i && !done_o) begin
            cnt <= cnt + 1;
            if (cnt >= lim) begin
                done_o <= 1'b1;
                fail_o <= fail_mode_i;
                cnt    <= 0;
                lim    <= $urandom_range(0, 5);
            end
        end
    end
endmodule // srdi_media_model

// *** verification/tb_top.sv ***
// self-checking bench of the command interpreter
`timescale 1ns/1ps
`include "srdi_consts.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    $display("[FAIL] %s exp %h got %h", n, e, g); num_errors++; end end
module tb_top;
    import srdi_pkg::*;
    logic        clk_i = 0, rst_n_i = 0, cyc = 0, stb = 0, we = 0;
    logic        nv_rdy = 1, fmode = 0, ack, dreq, m_done, m_fail, fbad;
    logic [7:0]  adr = 0;
    logic [31:0] wdat = 0, q, rdat, delem, r;
    logic [63:0] dcap;
    int          num_errors = 0, check_count = 0, cyc_cnt = 0;
    byte unsigned id_q[$];
    logic [63:0] cap_m = `SRDI_CAP_RST;
    localparam logic [63:0] EB = 64'h0000_0000_0400_0000;
    always #2 clk_i = ~clk_i;
    srdi_cmd_core #(.NUM_ELEM(4), .ID_BYTES(16), .ELEM_BLOCKS(EB)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf),
        .wb_dat_o(rdat), .wb_ack_o(ack), .nv_ready_i(nv_rdy),
        .media_done_i(m_done), .media_fail_i(m_fail), .depop_req_o(dreq),
        .depop_elem_o(delem), .depop_cap_o(dcap), .fmt_corrupt_o(fbad));
    srdi_media_model media (.clk_i(clk_i), .req_i(dreq),
        .fail_mode_i(fmode), .done_o(m_done), .fail_o(m_fail));
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= {a, 2'b00}; wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 0; stb <= 0; we <= 0;
    endtask
    task automatic run(input logic [127:0] c, input logic [31:0] ctl);
        for (int k = 0; k < 4; k++)
            wb(1, `SRDI_A_CDB0 + 6'(k), c[127-32*k -: 32]);
        wb(1, `SRDI_A_CTRL, ctl | 32'h0000_0001);
        do wb(0, `SRDI_A_STAT, 0); while (q[1] !== 1'b1 && q[3] !== 1'b1);
    endtask
    task automatic sense(string n, logic [3:0] k, logic [7:0] a,
                         logic [7:0] x);
        logic [7:0] s;
        s = (k == 0) ? `SRDI_ST_GOOD : `SRDI_ST_CHECK;
        wb(0, `SRDI_A_SENSE, 0);
        `CHK(n, {x, a, 4'h0, k, s}, q & 32'hffff_0fff)
    endtask
    function automatic logic [127:0] dp(logic [63:0] c, logic [31:0] e);
        return {`SRDI_OP_SA16, 3'b000, `SRDI_SA_DEPOP, c, e, 16'h0000};
    endfunction
    task automatic rep(input logic [15:0] lun, input int alloc);
        int n;
        logic [31:0] len;
        logic [7:0] e;
        len = id_q.size();
        run({`SRDI_OP_SA12, 3'b000, `SRDI_SA_REPID, 16'h0, lun, 32'(alloc),
             48'h0}, 0);
        n = (alloc < 4 + len) ? alloc : 4 + len;
        wb(0, `SRDI_A_XLEN, 0);
        `CHK("xlen", 32'(n), q)
        for (int i = 0; i < n; i++) begin
            wb(0, `SRDI_A_DATA, 0);
            e = (i < 4) ? len[31-8*i -: 8] : id_q[i-4];
            `CHK("byte", e, q[7:0])
        end
        sense("rep", 0, 0, 0);
    endtask
    initial begin
        void'($urandom(32'hcc38661f));
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1;
        repeat (8) @(posedge clk_i);
        rep(0, 64);
        wb(1, `SRDI_A_STLEN, 32'h0000_0006);
        for (int k = 0; k < 4; k++) begin
            r = $urandom;
            wb(1, `SRDI_A_STG0 + 6'(k), r);
            for (int b = 0; b < 4; b++)
                if (4 * k + b < 6) id_q.push_back(r[31-8*b -: 8]);
        end
        wb(1, `SRDI_A_CTRL, 32'h0000_0002);
        run({`SRDI_OP_REL10, 8'h10, 8'($urandom), 104'h0}, 0);
        sense("third", `SRDI_SK_ILL, `SRDI_ASC_FIELD, 0);
        wb(1, `SRDI_A_RESV, 32'h0000_0133);
        run({`SRDI_OP_REL10, 8'h00, 8'($urandom), 104'h0}, 0);
        sense("release", 0, 0, 0);
        wb(0, `SRDI_A_RESV, 0);
        `CHK("resv kept", 32'h0000_0133, q)
        wb(1, `SRDI_A_INIT, 32'h0000_0033);
        run({`SRDI_OP_REL10, 8'h00, 8'($urandom), 104'h0}, 0);
        sense("release own", 0, 0, 0);
        wb(0, `SRDI_A_RESV, 0);
        `CHK("resv freed", 32'h0000_0033, q)
        run(dp(0, 1), 32'h0000_0008);
        sense("ucode", `SRDI_SK_NRDY, `SRDI_ASC_NRDY, `SRDI_Q_UCODE);
        wb(1, `SRDI_A_CTRL, 0);
        wb(1, `SRDI_A_ELEMEN, 32'h0000_00fd);
        for (int e = 0; e < 3; e++) begin
            run(dp(0, (e == 0) ? 0 : (e == 1) ? 5 : 2), 0);
            sense("elem", `SRDI_SK_ILL, `SRDI_ASC_FIELD, 0);
        end
        run(dp(cap_m, 1), 0);
        sense("cap", `SRDI_SK_ILL, `SRDI_ASC_FIELD, 0);
        wb(0, `SRDI_A_CAPLO, 0);
        `CHK("cap kept", cap_m[31:0], q)
        run(dp(0, 1), 0);
        sense("depop", 0, 0, 0);
        cap_m = cap_m - EB;
        wb(0, `SRDI_A_CAPLO, 0);
        `CHK("cap new", cap_m[31:0], q)
        `CHK("elem out", 32'h0000_0001, delem)
        `CHK("cap out", cap_m, dcap)
        `CHK("req off", 1'b0, dreq)
        fmode <= 1;
        run(dp(0, 3), 0);
        fmode <= 0;
        `CHK("corrupt", 1'b1, fbad)
        sense("depfail", `SRDI_SK_MED, `SRDI_ASC_DEPOP, `SRDI_Q_DEPOP);
        run({8'h28, 120'h0}, 0);
        sense("medium", `SRDI_SK_MED, `SRDI_ASC_DEPOP, `SRDI_Q_DEPOP);
        wb(1, `SRDI_A_CTRL, 32'h0000_0004);
        `CHK("fmt ok", 1'b0, fbad)
        run({8'h28, 120'h0}, 0);
        sense("medium ok", 0, 0, 0);
        run({`SRDI_OP_SA12, 8'h05, 16'h0, 16'h0001, 32'h0000_0040, 48'h0}, 0);
        sense("lun", `SRDI_SK_ILL, `SRDI_ASC_FIELD, 0);
        nv_rdy <= 0;
        repeat (8) @(posedge clk_i);
        run({`SRDI_OP_SA12, 8'h05, 16'h0, 16'h0, 32'h0000_0040, 48'h0}, 0);
        sense("nv", `SRDI_SK_NRDY, `SRDI_ASC_NRDY, 0);
        nv_rdy <= 1;
        repeat (8) @(posedge clk_i);
        rep(0, 64);
        rep(0, 6);
        wb(1, `SRDI_A_INIT, $urandom);
        rep(0, 64);
        rst_n_i <= 0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1;
        repeat (8) @(posedge clk_i);
        rep(0, 64);
        final_report();
    end
endmodule // tb_top
